// File: core/arpc_ctrl.v
/*
 * Setup-byte decode, pair-configuration registers and reference power
 * sequencing for the externally clocked conversion mode.
 * Assumes a serial host drives cs_n, sclk and mosi; sclk is far slower than
 * clock (800 ns against 100 ns) so every edge is seen after synchronising.
 * Scan and temperature requests come from converter logic on clock.
 */
`timescale 1ns/100ps
`include "arpc_regs.vh"

module arpc_ctrl (
    input  wire        clock,
    input  wire        arst_n,
    input  wire        cs_n,
    input  wire        sclk,
    input  wire        mosi,
    input  wire        scan_req,
    input  wire        scan_done,
    input  wire        temp_req,
    input  wire [9:0]  temp_result,
    output reg         miso_ff,
    output reg         miso_oe_n_ff,
    output reg         ref_power_ff,
    output reg         conv_go_ff,
    output reg         temp_valid_ff,
    output reg  [1:0]  clock_mode_ff,
    output reg  [1:0]  ref_select_ff,
    output wire        adc_uses_int_ref,
    output wire        dac_uses_ref_pin,
    output reg  [7:0]  pair_unipolar_diff_config_ff,
    output reg  [7:0]  pair_bipolar_diff_config_ff,
    output wire [7:0]  pair_function
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_WAKE  = 3'h1;
    localparam ST_CONV  = 3'h2;
    localparam ST_TWAKE = 3'h3;
    localparam ST_TOUT  = 3'h4;

    wire       cs_n_s;
    wire       sclk_s;
    wire       mosi_s;
    reg        sclk_d_ff;
    reg  [2:0] bit_cnt_ff;
    reg  [7:0] shift_ff;
    reg        data_pend_ff;
    reg        data_bip_ff;
    reg  [2:0] state_ff;
    reg  [2:0] nxt_state;
    reg  [7:0] cyc_ff;
    reg  [7:0] nxt_cyc;
    reg        ref_warm_ff;
    reg  [9:0] tshift_ff;
    wire       sclk_rise;
    wire       sclk_fall;
    wire [7:0] byte_in;
    wire       byte_done;
    wire       ext_mode;

    arpc_sync u_sync_cs (.clock(clock), .arst_n(arst_n), .din(cs_n), .dout(cs_n_s));
    arpc_sync u_sync_ck (.clock(clock), .arst_n(arst_n), .din(sclk), .dout(sclk_s));
    arpc_sync u_sync_di (.clock(clock), .arst_n(arst_n), .din(mosi), .dout(mosi_s));

    // ****************************************************************
    // Serial clock edges; in clock mode 11 these are the conversion clock
    // ****************************************************************
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            sclk_d_ff <= 1'b0;
        else
            sclk_d_ff <= sclk_s;
    end

    assign sclk_rise = sclk_s & ~sclk_d_ff & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_d_ff;
    assign byte_in   = {shift_ff[6:0], mosi_s};
    assign byte_done = sclk_rise && (bit_cnt_ff == 3'h7);
    assign ext_mode  = (clock_mode_ff == `ARPC_CLK_MODE_EXT);

    // ****************************************************************
    // Byte assembly and setup decode
    // ****************************************************************
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bit_cnt_ff                   <= 3'h0;
            shift_ff                     <= 8'h00;
            data_pend_ff                 <= 1'b0;
            data_bip_ff                  <= 1'b0;
            clock_mode_ff                <= `ARPC_CLK_MODE_RESET;
            ref_select_ff                <= `ARPC_REF_SEL_RESET;
            pair_unipolar_diff_config_ff <= `ARPC_PAIR_REG_RESET;
            pair_bipolar_diff_config_ff  <= `ARPC_PAIR_REG_RESET;
        end else if (cs_n_s) begin
            // A frame cut short drops a pending data byte
            bit_cnt_ff   <= 3'h0;
            data_pend_ff <= 1'b0;
        end else if (sclk_rise) begin
            shift_ff   <= byte_in;
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (byte_done) begin
                if (data_pend_ff) begin
                    data_pend_ff <= 1'b0;
                    // Low nibble kept only as written; nothing decodes it
                    if (data_bip_ff)
                        pair_bipolar_diff_config_ff <= byte_in;
                    else
                        pair_unipolar_diff_config_ff <= byte_in;
                end else if (byte_in[`ARPC_SETUP_ID_HI:`ARPC_SETUP_ID_LO] == `ARPC_SETUP_ID_VAL) begin
                    clock_mode_ff <= byte_in[`ARPC_CLK_MODE_HI:`ARPC_CLK_MODE_LO];
                    ref_select_ff <= byte_in[`ARPC_REF_SEL_HI:`ARPC_REF_SEL_LO];
                    // Codes 00 and 01 leave the next byte as a fresh command
                    data_pend_ff  <= byte_in[`ARPC_PAIR_SEL_HI];
                    data_bip_ff   <= byte_in[`ARPC_PAIR_SEL_LO];
                end
            end
        end
    end

    // ****************************************************************
    // Pair function decode, two bits per pair, pair 0/1 in bits 1:0
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_pair
            wire uni = pair_unipolar_diff_config_ff[`ARPC_PAIR_FIELD_HI - gi];
            wire bip = pair_bipolar_diff_config_ff[`ARPC_PAIR_FIELD_HI - gi];
            assign pair_function[2*gi+1:2*gi] = uni ? `ARPC_PF_UNI_DIFF :
                                                bip ? `ARPC_PF_BIP_DIFF : `ARPC_PF_UNI_SE;
        end
    endgenerate

    // Default code 10 is internal for the converter, pin reference for DAC
    assign adc_uses_int_ref = (ref_select_ff == `ARPC_REF_SEL_INT) ||
                              (ref_select_ff == `ARPC_REF_SEL_DEFAULT);
    assign dac_uses_ref_pin = (ref_select_ff != `ARPC_REF_SEL_INT);

    // ****************************************************************
    // Reference sequencing, counted on conversion clock edges
    // ****************************************************************
    always @* begin
        nxt_state = state_ff;
        nxt_cyc   = cyc_ff;
        case (state_ff)
            ST_IDLE: begin
                if (ext_mode && temp_req) begin
                    nxt_state = ST_TWAKE;
                    nxt_cyc   = 8'h00;
                end else if (ext_mode && scan_req && adc_uses_int_ref && !ref_warm_ff) begin
                    nxt_state = ST_WAKE;
                    nxt_cyc   = 8'h00;
                end else if (ext_mode && scan_req) begin
                    nxt_state = ST_CONV;
                end
            end
            ST_WAKE: begin
                if (sclk_rise) begin
                    nxt_cyc = cyc_ff + 8'h01;
                    if (cyc_ff == 8'd`ARPC_AIN_WAKE_CYC - 8'h01)
                        nxt_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (scan_done)
                    nxt_state = ST_IDLE;
            end
            ST_TWAKE: begin
                if (sclk_rise) begin
                    nxt_cyc = cyc_ff + 8'h01;
                    if (cyc_ff == 8'd`ARPC_TEMP_WAKE_CYC - 8'h01) begin
                        nxt_state = ST_TOUT;
                        nxt_cyc   = 8'h00;
                    end
                end
            end
            ST_TOUT: begin
                if (sclk_rise) begin
                    nxt_cyc = cyc_ff + 8'h01;
                    if (cyc_ff == 8'd`ARPC_TEMP_OUT_CYC - 8'h01)
                        nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_cyc   = 8'h00;
            end
        endcase
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff      <= ST_IDLE;
            cyc_ff        <= 8'h00;
            ref_warm_ff   <= 1'b0;
            ref_power_ff  <= 1'b0;
            conv_go_ff    <= 1'b0;
            temp_valid_ff <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            cyc_ff        <= nxt_cyc;
            conv_go_ff    <= (state_ff != ST_CONV) && (nxt_state == ST_CONV);
            temp_valid_ff <= (state_ff == ST_TOUT) && (nxt_state == ST_IDLE);
            if (nxt_state == ST_WAKE || nxt_state == ST_TWAKE)
                ref_power_ff <= 1'b1;
            else if (state_ff == ST_CONV && scan_done && adc_uses_int_ref)
                ref_power_ff <= 1'b0;
            else if (state_ff == ST_TOUT && nxt_state == ST_IDLE && !adc_uses_int_ref)
                ref_power_ff <= 1'b0;
            // Reference counts as settled only while powered after a wake
            if (state_ff == ST_WAKE && nxt_state == ST_CONV)
                ref_warm_ff <= 1'b1;
            else if (state_ff == ST_CONV && scan_done)
                ref_warm_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // Temperature result out, msb first, changed on falling serial clock
    // ****************************************************************
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tshift_ff    <= 10'h000;
            miso_ff      <= 1'b0;
            miso_oe_n_ff <= 1'b1;
        end else begin
            if (temp_valid_ff) begin
                tshift_ff    <= {temp_result[8:0], 1'b0};
                miso_ff      <= temp_result[9];
                miso_oe_n_ff <= 1'b0;
            end else if (cs_n_s) begin
                miso_oe_n_ff <= 1'b1;
            end else if (sclk_fall && !miso_oe_n_ff) begin
                miso_ff   <= tshift_ff[9];
                tshift_ff <= {tshift_ff[8:0], 1'b0};
            end
        end
    end
endmodule

// File: pkg/arpc_regs.vh
/*
 * Field positions, encodings, reset values and timing counts for the
 * converter setup decode block. Assumes nothing beyond a Verilog-2005 tool.
 */
`ifndef ARPC_REGS_VH
`define ARPC_REGS_VH

// ****************************************************************
// Setup byte fields
// ****************************************************************
`define ARPC_SETUP_ID_HI        7
`define ARPC_SETUP_ID_LO        6
`define ARPC_SETUP_ID_VAL       2'h1
`define ARPC_CLK_MODE_HI        5
`define ARPC_CLK_MODE_LO        4
`define ARPC_REF_SEL_HI         3
`define ARPC_REF_SEL_LO         2
`define ARPC_PAIR_SEL_HI        1
`define ARPC_PAIR_SEL_LO        0

// ****************************************************************
// Encodings
// ****************************************************************
`define ARPC_CLK_MODE_EXT       2'h3
`define ARPC_CLK_MODE_RESET     2'h2
`define ARPC_REF_SEL_INT        2'h0
`define ARPC_REF_SEL_EXT_SE     2'h1
`define ARPC_REF_SEL_DEFAULT    2'h2
`define ARPC_REF_SEL_EXT_DIFF   2'h3
`define ARPC_REF_SEL_RESET      2'h2
`define ARPC_PAIR_SEL_UNI       2'h2
`define ARPC_PAIR_SEL_BIP       2'h3

// ****************************************************************
// Pair registers: bit 7 is pair 0/1 down to bit 4 pair 6/7
// ****************************************************************
`define ARPC_PAIR_FIELD_HI      7
`define ARPC_PAIR_FIELD_LO      4
`define ARPC_PAIR_REG_RESET     8'h00

// ****************************************************************
// Pair function codes
// ****************************************************************
`define ARPC_PF_UNI_SE          2'h0
`define ARPC_PF_BIP_DIFF        2'h1
`define ARPC_PF_UNI_DIFF        2'h2

// ****************************************************************
// Timing, in external conversion clock cycles, and the external clock limit in kHz
// ****************************************************************
`define ARPC_AIN_WAKE_CYC       218
`define ARPC_TEMP_WAKE_CYC      244
`define ARPC_TEMP_OUT_CYC       188
`define ARPC_EXT_CLK_MAX_KHZ    3600

`endif

// File: core/arpc_sync.v
/*
 * Two-flop synchroniser for one level from outside the clock domain.
 * Assumes the input is a plain level or a slow clock pin.
 */
`timescale 1ns/100ps

module arpc_sync (
    input  wire clock,
    input  wire arst_n,
    input  wire din,
    output wire dout
);
    reg meta_ff;
    reg sync_ff;

    // First flop feeds only the second
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule

// File: sim/arpc_props.sv
/* Concurrent checks on the ports of arpc_ctrl.
   Assumes one clock domain and the asynchronous active-low reset. */
`timescale 1ns/100ps
`include "arpc_regs.vh"
module arpc_props (
    input wire       clock,
    input wire       arst_n,
    input wire       cs_n,
    input wire [9:0] temp_result,
    input wire       miso_ff,
    input wire       miso_oe_n_ff,
    input wire       ref_power_ff,
    input wire       conv_go_ff,
    input wire       temp_valid_ff,
    input wire [1:0] clock_mode_ff,
    input wire [1:0] ref_select_ff,
    input wire       adc_uses_int_ref,
    input wire       dac_uses_ref_pin,
    input wire [7:0] pair_unipolar_diff_config_ff,
    input wire [7:0] pair_bipolar_diff_config_ff,
    input wire [7:0] pair_function
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    // Unipolar bit wins over bipolar bit
    function [1:0] pf(input u, input b);
        pf = u ? `ARPC_PF_UNI_DIFF : (b ? `ARPC_PF_BIP_DIFF : `ARPC_PF_UNI_SE);
    endfunction
    wire [7:0] u = pair_unipolar_diff_config_ff;
    wire [7:0] b = pair_bipolar_diff_config_ff;
    a_pair_decode: assert property (pair_function == {pf(u[4], b[4]), pf(u[5], b[5]), pf(u[6], b[6]), pf(u[7], b[7])})
        else $error("pair function decode wrong");
    a_adc_int_ref: assert property (adc_uses_int_ref == !ref_select_ff[0])
        else $error("adc reference choice wrong");
    a_dac_ref_pin: assert property (dac_uses_ref_pin == (ref_select_ff != 2'h0))
        else $error("dac reference choice wrong");
    a_go_ref_on: assert property (conv_go_ff && !ref_select_ff[0] |-> ref_power_ff)
        else $error("conversion started with reference off");
    a_go_one_pulse: assert property (conv_go_ff |=> !conv_go_ff)
        else $error("conversion start longer than one cycle");
    a_ext_mode_only: assert property (conv_go_ff || temp_valid_ff |-> clock_mode_ff == `ARPC_CLK_MODE_EXT)
        else $error("sequencing outside external clock mode");
    a_temp_ref_on: assert property (temp_valid_ff |-> $past(ref_power_ff) ##1 !temp_valid_ff)
        else $error("temperature result without reference");
    a_temp_msb_out: assert property (temp_valid_ff |=> !miso_oe_n_ff && miso_ff == $past(temp_result[9]))
        else $error("temperature msb not driven");
    a_pairs_hold: assert property (cs_n [*4] |-> $stable(u) && $stable(b))
        else $error("pair register changed outside a frame");
    c_conv: cover property (conv_go_ff);
    c_temp: cover property (temp_valid_ff);
    c_bip: cover property ($changed(b));
endmodule

// File: sim/arpc_host.sv
/* Serial host model: frames of whole bytes and free sclk runs with cs_n low.
   Assumes the 10 MHz system clock; sclk period is 8 system clocks. */
`timescale 1ns/100ps
module arpc_host (
    input  wire clock,
    output reg  cs_n,
    output reg  sclk,
    output reg  mosi
);
    integer i;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end
    task half; begin
        repeat (4) @(posedge clock);
        #10;
    end endtask
    task put(input bv); begin
        mosi = bv;
        half;
        sclk = 1'b1;
        half;
        sclk = 1'b0;
    end endtask
    task start; begin
        cs_n = 1'b0;
        half;
    end endtask
    // Released data line shows the inverse, so a stale value cannot pass
    // Chip select stays high for a half period so back-to-back frames stay apart
    task stop; begin
        half;
        cs_n = 1'b1;
        mosi = ~mosi;
        half;
    end endtask
    task xfer8(input [7:0] w); begin
        start;
        for (i = 7; i >= 0; i = i - 1) put(w[i]);
        stop;
    end endtask
    task xfer16(input [15:0] w); begin
        start;
        for (i = 15; i >= 0; i = i - 1) put(w[i]);
        stop;
    end endtask
    // Zero bytes decode as foreign commands and are dropped
    task run(input integer n); begin
        start;
        repeat (n) put(1'b0);
        stop;
    end endtask
endmodule

// File: sim/tb_adc_ref_and_pair_config.sv
/* Self-checking bench for arpc_ctrl driven through the serial host model.
   Assumes arpc_props and arpc_host are compiled first. */
`timescale 1ns/100ps
module tb_adc_ref_and_pair_config;
    reg        clock = 1'b0;
    reg        arst_n = 1'b0;
    reg        scan_req = 1'b0;
    reg        scan_done = 1'b0;
    reg        temp_req = 1'b0;
    reg  [9:0] temp_result = 10'h2A5;
    wire       cs_n, sclk, mosi, miso, miso_oe_n, ref_power, conv_go, temp_valid, adc_int, dac_pin;
    wire [1:0] clock_mode, ref_select;
    wire [7:0] uni, bip, pfunc;
    integer    error_cnt = 0;
    integer    n_checks = 0;
    integer    rises = 0;
    integer    r;
    always #50 clock = ~clock;
    always @(posedge sclk) rises = rises + 1;
    arpc_host u_host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));
    arpc_ctrl u_dut (.clock(clock), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
        .scan_req(scan_req), .scan_done(scan_done), .temp_req(temp_req), .temp_result(temp_result),
        .miso_ff(miso), .miso_oe_n_ff(miso_oe_n), .ref_power_ff(ref_power), .conv_go_ff(conv_go),
        .temp_valid_ff(temp_valid), .clock_mode_ff(clock_mode), .ref_select_ff(ref_select),
        .adc_uses_int_ref(adc_int), .dac_uses_ref_pin(dac_pin), .pair_unipolar_diff_config_ff(uni),
        .pair_bipolar_diff_config_ff(bip), .pair_function(pfunc));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task check(input [23:0] seen, input [23:0] exp); begin
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end endtask
    task tally_and_finish; begin
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end endtask
    // sel 0 scan request, 1 scan done, 2 temperature request
    task pulse(input [1:0] sel); begin
        @(posedge clock);
        #10;
        {temp_req, scan_done, scan_req} = 3'h1 << sel;
        @(posedge clock);
        #10;
        {temp_req, scan_done, scan_req} = 3'h0;
    end endtask
    // Request is raised while sclk is idle, so every counted rise follows it
    task timed(input [1:0] sel, input [15:0] exp);
        integer k;
        begin
            rises = 0;
            k = 0;
            fork
                u_host.run(exp + 8);
                begin
                    pulse(sel);
                    while ((sel == 2'h2 ? temp_valid : conv_go) !== 1'b1 && k < 6000) begin
                        @(posedge clock);
                        #10;
                        k = k + 1;
                    end
                    check(rises, exp);
                    if (sel == 2'h2) begin
                        @(posedge clock);
                        #10;
                        check({miso_oe_n, miso}, {1'b0, temp_result[9]});
                    end else
                        check(ref_power, 1'b1);
                end
            join
        end
    endtask
    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        repeat (3) @(posedge clock);
        #10 arst_n = 1'b1;
        check({clock_mode, ref_select, uni, bip}, 20'hA0000);
        check({pfunc, ref_power, miso_oe_n, adc_int, dac_pin}, 12'h007);
        u_host.xfer16(16'h7AA0);
        check({clock_mode, uni, pfunc}, {2'h3, 8'hA0, 8'h22});
        u_host.xfer16(16'h7B50);
        check({bip, pfunc}, 16'h5066);
        for (r = 0; r < 2; r = r + 1) begin
            u_host.xfer16({6'h1E, r[1:0], 8'hF0});
            check({uni, bip}, 16'hA050);
        end
        u_host.xfer16(16'h7A0F);
        check({uni, pfunc}, 16'h0F44);
        timed(2'h0, 16'd218);
        pulse(2'h1);
        @(posedge clock);
        #10;
        check(ref_power, 1'b0);
        for (r = 0; r < 4; r = r + 1) begin
            u_host.xfer8({4'h7, r[1:0], 2'h0});
            timed(2'h2, 16'd432);
        end
        // External reference: scan starts at once and the reference stays off
        u_host.xfer8(8'h74);
        pulse(2'h0);
        check({conv_go, ref_power}, 2'h2);
        pulse(2'h1);
        // Clock mode 10: requests are ignored by this sequencer
        u_host.xfer8(8'h68);
        pulse(2'h2);
        check({clock_mode, ref_power, temp_valid, conv_go}, 5'h10);
        pulse(2'h0);
        check({ref_power, conv_go}, 2'h0);
        tally_and_finish;
    end
    initial begin
        #3000000;
        error_cnt = error_cnt + 1;
        tally_and_finish;
    end
endmodule
bind arpc_ctrl arpc_props u_props (.clock(clock), .arst_n(arst_n), .cs_n(cs_n), .temp_result(temp_result),
    .miso_ff(miso_ff), .miso_oe_n_ff(miso_oe_n_ff), .ref_power_ff(ref_power_ff), .conv_go_ff(conv_go_ff),
    .temp_valid_ff(temp_valid_ff), .clock_mode_ff(clock_mode_ff), .ref_select_ff(ref_select_ff),
    .adc_uses_int_ref(adc_uses_int_ref), .dac_uses_ref_pin(dac_uses_ref_pin),
    .pair_unipolar_diff_config_ff(pair_unipolar_diff_config_ff),
    .pair_bipolar_diff_config_ff(pair_bipolar_diff_config_ff), .pair_function(pair_function));
